//--- verilog/err_counters.sv
// Operation
// - ESF: count each failed CRC6 codeword
// - D4: count each Ft bit error
// - D4 option adds Fs errors; ESF ignores it
// - T1 path count held while sync lost
// - E1: count each CRC4 block error
// - E1 path count held on FAS/CRC4 loss
// - Path count 16 bits at 44h/45h
// - T1 OOS mode: count multiframes out of sync
// - T1 F-bit mode: Ft/FPS errors, held on loss
// - E1: count FAS word errors, held on loss
// - E1: no FAS counting while searching alignment
// - Frame sync count 16 bits at 46h/47h
// - E-bit counter counts in E1 only
// - CRC4 multiframe: count each zero E-bit
// - E-bit count held on FAS/CRC4 loss
// - E-bit count 16 bits at 48h/49h
// - Counters saturate, never wrap
// - Auto update: one second or short interval
// - Manual bit rising edge latches and clears
`timescale 1ns/1ps
`default_nettype none
`include "err_cnt_regs.svh"

module err_counters
   import err_cnt_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Receive framer indications, all on pclk
   input  wire logic        rx_e1_mode,
   input  wire logic        rx_esf_mode,
   input  wire logic        rx_crc4_mode,
   input  wire logic        frame_strobe,
   input  wire logic        multiframe_strobe,
   input  wire logic        receive_sync_lost,
   input  wire logic        fas_sync_lost,
   input  wire logic        crc4_sync_lost,
   input  wire logic        fas_search,
   input  wire logic        mf_search,
   input  wire logic        crc6_err,
   input  wire logic        ft_err,
   input  wire logic        fs_err,
   input  wire logic        fps_err,
   input  wire logic        crc4_err,
   input  wire logic        fas_word_err,
   input  wire logic        ebit_zero
);

   byte_t       error_counter_config_r;   // Configuration register
   byte_t       error_counter_config_nxt;
   logic        manual_prev_r;             // Manual bit as seen last cycle
   logic        pready_r;                  // Access phase completes next edge
   logic        pready_nxt;
   logic        pslverr_r;
   logic        pslverr_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;

   line_mode_t  mode;                      // Decoded framing mode
   logic        fs_error_report_enable;
   logic        oos_or_fbit_count_select;
   logic        accumulation_mode_select;
   logic        update_interval_select;
   logic        manual_count_latch;
   logic        manual_edge;               // Manual bit just went 0 to 1
   logic        timer_tick;                // Automatic interval boundary
   logic        latch;                     // Snapshot and restart all counters
   logic        pv_inc;                    // Path violation event
   logic        fs_inc;                    // Frame sync event
   logic        eb_inc;                    // Far-end block error event
   logic        access;                    // APB access phase in progress
   logic        done;                      // Edge at which the master samples pready
   logic        hit;                       // Address maps to a register
   count_t      path_violation_counter;
   count_t      frame_sync_error_counter;
   count_t      far_end_block_error_counter;

   // Word index match on the aligned APB address
   function automatic logic is_idx(input logic [11:0] addr, input logic [9:0] idx);
      return addr[11:2] == idx;
   endfunction : is_idx

   assign fs_error_report_enable   = error_counter_config_r[`CFG_FS_REPORT_BIT];
   assign oos_or_fbit_count_select = error_counter_config_r[`CFG_OOS_POS];
   assign accumulation_mode_select = error_counter_config_r[`CFG_ACCUM_BIT];
   assign update_interval_select   = error_counter_config_r[`CFG_INTERVAL_BIT];
   assign manual_count_latch       = error_counter_config_r[`CFG_MANUAL_BIT];

   // Framing mode from the framer's two mode lines
   always_comb begin
      if (rx_e1_mode) begin
         mode = MODE_E1;
      end else if (rx_esf_mode) begin
         mode = MODE_T1_ESF;
      end else begin
         mode = MODE_T1_D4;
      end
   end

   // Event qualification per mode; the hold conditions gate the strobes directly
   always_comb begin
      pv_inc = 1'b0;
      fs_inc = 1'b0;
      eb_inc = 1'b0;
      unique case (mode)
         MODE_T1_D4: begin
            // Fs errors only when reporting is enabled
            pv_inc = !receive_sync_lost
                     && (ft_err || (fs_error_report_enable && fs_err));
            if (oos_or_fbit_count_select) begin
               fs_inc = multiframe_strobe && receive_sync_lost;
            end else begin
               fs_inc = !receive_sync_lost && ft_err;
            end
         end
         MODE_T1_ESF: begin
            // The Fs option has no meaning here
            pv_inc = !receive_sync_lost && crc6_err;
            if (oos_or_fbit_count_select) begin
               fs_inc = multiframe_strobe && receive_sync_lost;
            end else begin
               fs_inc = !receive_sync_lost && fps_err;
            end
         end
         MODE_E1: begin
            // CAS multiframe loss alone does not stop path or E-bit counting
            pv_inc = !fas_sync_lost && !crc4_sync_lost && crc4_err;
            fs_inc = !receive_sync_lost && !fas_search && !mf_search
                     && fas_word_err;
            eb_inc = rx_crc4_mode && !fas_sync_lost && !crc4_sync_lost
                     && ebit_zero;
         end
         default: begin
            pv_inc = 1'b0;
         end
      endcase
   end

   // Latch source: timer in automatic mode, rising manual bit otherwise
   assign manual_edge = manual_count_latch && !manual_prev_r;
   assign latch = accumulation_mode_select ? manual_edge : timer_tick;

   update_timer u_timer (
      .pclk           (pclk),
      .presetn        (presetn),
      .frame_strobe   (frame_strobe),
      .e1_mode        (rx_e1_mode),
      .short_interval (update_interval_select),
      .tick_r         (timer_tick)
   );

   sat_counter u_pv (
      .pclk    (pclk),
      .presetn (presetn),
      .inc     (pv_inc),
      .latch   (latch),
      .held_r  (path_violation_counter)
   );

   sat_counter u_fs (
      .pclk    (pclk),
      .presetn (presetn),
      .inc     (fs_inc),
      .latch   (latch),
      .held_r  (frame_sync_error_counter)
   );

   sat_counter u_eb (
      .pclk    (pclk),
      .presetn (presetn),
      .inc     (eb_inc),
      .latch   (latch),
      .held_r  (far_end_block_error_counter)
   );

   // APB decode: one wait state, then pready for a single cycle
   assign access = psel && penable;
   assign done   = access && pready_r;
   assign hit    = is_idx(paddr, `IDX_CFG)
                || is_idx(paddr, `IDX_PV_HIGH) || is_idx(paddr, `IDX_PV_LOW)
                || is_idx(paddr, `IDX_FS_HIGH) || is_idx(paddr, `IDX_FS_LOW)
                || is_idx(paddr, `IDX_EB_HIGH) || is_idx(paddr, `IDX_EB_LOW);

   // Bus answer and register write
   always_comb begin
      pready_nxt               = access && !pready_r;
      pslverr_nxt              = access && !pready_r && !hit;
      prdata_nxt               = 32'h0000_0000;
      error_counter_config_nxt = error_counter_config_r;
      // Only the configuration is writable; count writes fall on the floor
      if (done && pwrite && is_idx(paddr, `IDX_CFG)) begin
         error_counter_config_nxt = pwdata[7:0] & `CFG_WRITE_MASK;
      end
      if (access && !pready_r && !pwrite) begin
         if (is_idx(paddr, `IDX_CFG)) begin
            prdata_nxt[7:0] = error_counter_config_r;
         end else if (is_idx(paddr, `IDX_PV_HIGH)) begin
            prdata_nxt[7:0] = path_violation_counter[15:8];
         end else if (is_idx(paddr, `IDX_PV_LOW)) begin
            prdata_nxt[7:0] = path_violation_counter[7:0];
         end else if (is_idx(paddr, `IDX_FS_HIGH)) begin
            prdata_nxt[7:0] = frame_sync_error_counter[15:8];
         end else if (is_idx(paddr, `IDX_FS_LOW)) begin
            prdata_nxt[7:0] = frame_sync_error_counter[7:0];
         end else if (is_idx(paddr, `IDX_EB_HIGH)) begin
            prdata_nxt[7:0] = far_end_block_error_counter[15:8];
         end else if (is_idx(paddr, `IDX_EB_LOW)) begin
            prdata_nxt[7:0] = far_end_block_error_counter[7:0];
         end else begin
            prdata_nxt = 32'h0000_0000;
         end
      end
   end

   // Bus and configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_counter_config_r <= `CFG_RESET;
         manual_prev_r          <= 1'b0;
         pready_r               <= 1'b0;
         pslverr_r              <= 1'b0;
         prdata_r               <= 32'h0000_0000;
      end else begin
         error_counter_config_r <= error_counter_config_nxt;
         manual_prev_r          <= manual_count_latch;
         pready_r               <= pready_nxt;
         pslverr_r              <= pslverr_nxt;
         prdata_r               <= prdata_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;

   a_pv_esf_crc6: assert property (@(posedge pclk) disable iff (!presetn)
      mode == MODE_T1_ESF && crc6_err && !receive_sync_lost |-> pv_inc)
      else $error("ESF CRC6 error not counted");

   a_pv_d4_ft: assert property (@(posedge pclk) disable iff (!presetn)
      mode == MODE_T1_D4 && ft_err && !receive_sync_lost |-> pv_inc)
      else $error("D4 Ft error not counted");

   a_pv_fs_option: assert property (@(posedge pclk) disable iff (!presetn)
      mode == MODE_T1_D4 && fs_err && !ft_err && !receive_sync_lost
      |-> pv_inc == fs_error_report_enable)
      else $error("Fs reporting option misapplied");

   a_pv_t1_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !rx_e1_mode && receive_sync_lost |-> !pv_inc)
      else $error("T1 path count moved during sync loss");

   a_pv_e1_crc4: assert property (@(posedge pclk) disable iff (!presetn)
      rx_e1_mode && crc4_err |-> pv_inc == (!fas_sync_lost && !crc4_sync_lost))
      else $error("E1 CRC4 counting wrong");

   a_fs_oos_count: assert property (@(posedge pclk) disable iff (!presetn)
      !rx_e1_mode && oos_or_fbit_count_select
      |-> fs_inc == (multiframe_strobe && receive_sync_lost))
      else $error("out-of-sync multiframe count wrong");

   a_fs_fbit_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !rx_e1_mode && !oos_or_fbit_count_select && receive_sync_lost |-> !fs_inc)
      else $error("F-bit count moved during sync loss");

   a_fs_e1_search: assert property (@(posedge pclk) disable iff (!presetn)
      rx_e1_mode && (receive_sync_lost || fas_search || mf_search) |-> !fs_inc)
      else $error("FAS error counted while searching");

   a_eb_e1_only: assert property (@(posedge pclk) disable iff (!presetn)
      !rx_e1_mode |-> !eb_inc)
      else $error("E-bit counted in T1 mode");

   a_eb_count: assert property (@(posedge pclk) disable iff (!presetn)
      rx_e1_mode && rx_crc4_mode && ebit_zero
      |-> eb_inc == (!fas_sync_lost && !crc4_sync_lost))
      else $error("E-bit counting wrong");

   a_manual_latch: assert property (@(posedge pclk) disable iff (!presetn)
      accumulation_mode_select && manual_count_latch && !manual_prev_r |-> latch
      ##1 !latch)
      else $error("manual update did not latch exactly once");

   a_read_pv_high: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready_r && !pwrite && is_idx(paddr, `IDX_PV_HIGH)
      |=> pready && prdata == {24'h00_0000, $past(path_violation_counter[15:8])})
      else $error("path count high byte misread");

   a_count_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      done && pwrite && !is_idx(paddr, `IDX_CFG) |=> $stable(error_counter_config_r))
      else $error("write to a count register changed configuration");

   // Mode gating, update source, bus read and refusal; a slip here corrupts counts silently
   a_eb_needs_crc4: assert property (@(posedge pclk) disable iff (!presetn)
      rx_e1_mode && !rx_crc4_mode |-> !eb_inc)
      else $error("E-bit counted without CRC4 multiframe");

   a_fs_e1_count: assert property (@(posedge pclk) disable iff (!presetn)
      rx_e1_mode && fas_word_err && !receive_sync_lost && !fas_search && !mf_search
      |-> fs_inc)
      else $error("E1 FAS word error not counted");

   a_auto_latch_tick: assert property (@(posedge pclk) disable iff (!presetn)
      !accumulation_mode_select |-> latch == timer_tick)
      else $error("automatic update not driven by the timer");

   a_manual_only_edge: assert property (@(posedge pclk) disable iff (!presetn)
      accumulation_mode_select && !(manual_count_latch && !manual_prev_r)
      |-> !latch)
      else $error("manual mode latched without a rising edge");

   a_read_eb_low: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready_r && !pwrite && is_idx(paddr, `IDX_EB_LOW)
      |=> pready && prdata == {24'h00_0000, $past(far_end_block_error_counter[7:0])})
      else $error("E-bit count low byte misread");

   a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready_r && !hit |=> pready && pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   c_manual_latch: cover property (@(posedge pclk) disable iff (!presetn)
      accumulation_mode_select && manual_edge);

   c_auto_latch: cover property (@(posedge pclk) disable iff (!presetn)
      !accumulation_mode_select && timer_tick);

   c_e1_ebit: cover property (@(posedge pclk) disable iff (!presetn) eb_inc);

   c_read_done: cover property (@(posedge pclk) disable iff (!presetn) done && !pwrite);

   c_t1_oos_count: cover property (@(posedge pclk) disable iff (!presetn)
      !rx_e1_mode && fs_inc && receive_sync_lost);

endmodule : err_counters

`default_nettype wire

//--- verilog/err_cnt_regs.svh
`ifndef ERR_CNT_REGS_SVH
`define ERR_CNT_REGS_SVH

// Register indices; the APB byte address is four times the index
`define IDX_CFG          10'h041
`define IDX_PV_HIGH      10'h044
`define IDX_PV_LOW       10'h045
`define IDX_FS_HIGH      10'h046
`define IDX_FS_LOW       10'h047
`define IDX_EB_HIGH      10'h048
`define IDX_EB_LOW       10'h049

// Configuration field positions
`define CFG_OOS_POS       1
`define CFG_FS_REPORT_BIT 2
`define CFG_ACCUM_BIT     4
`define CFG_INTERVAL_BIT  5
`define CFG_MANUAL_BIT    6

// Writable configuration bits and reset values
`define CFG_WRITE_MASK   8'h76
`define CFG_RESET        8'h00
`define CNT_RESET        16'h0000
`define CNT_MAX          16'hFFFF
`define CNT_ONE          16'h0001

// Update intervals counted in received frames
`define FRAMES_ONE_SEC   13'h1F40
`define FRAMES_T1_SHORT  13'h014D
`define FRAMES_E1_SHORT  13'h01F4
`define FRAME_ONE        13'h0001

`endif

//--- verilog/err_cnt_pkg.sv
package err_cnt_pkg;

   // Receive framing mode, Gray coded from D4 through ESF to E1
   typedef enum logic [1:0] {
      MODE_T1_D4  = 2'b00,
      MODE_T1_ESF = 2'b01,
      MODE_E1     = 2'b11
   } line_mode_t;

   typedef logic [15:0] count_t;
   typedef logic [7:0]  byte_t;

endpackage : err_cnt_pkg

//--- verilog/sat_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "err_cnt_regs.svh"

module sat_counter
   import err_cnt_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic inc,
   input  wire logic latch,
   output count_t    held_r
);

   count_t live_r;   // Running count of the current interval
   count_t live_nxt;
   count_t held_nxt; // Readable snapshot

   // Saturating increment; the count must never wrap to zero
   function automatic count_t sat_inc(input count_t v);
      return (v == `CNT_MAX) ? v : count_t'(v + `CNT_ONE);
   endfunction : sat_inc

   // Latch copies and restarts; an event in the latch cycle opens the new interval
   always_comb begin
      live_nxt = live_r;
      held_nxt = held_r;
      if (latch) begin
         held_nxt = live_r;
         live_nxt = inc ? `CNT_ONE : `CNT_RESET;
      end else if (inc) begin
         live_nxt = sat_inc(live_r);
      end
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         live_r <= `CNT_RESET;
         held_r <= `CNT_RESET;
      end else begin
         live_r <= live_nxt;
         held_r <= held_nxt;
      end
   end

   a_sat_no_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (live_r == `CNT_MAX) && inc && !latch |=> live_r == `CNT_MAX)
      else $error("counter wrapped past its maximum");

   a_latch_copy: assert property (@(posedge pclk) disable iff (!presetn)
      latch |=> held_r == $past(live_r) && live_r == ($past(inc) ? `CNT_ONE : `CNT_RESET))
      else $error("latch did not copy and restart");

endmodule : sat_counter

`default_nettype wire

//--- verilog/update_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "err_cnt_regs.svh"

module update_timer (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic frame_strobe,
   input  wire logic e1_mode,
   input  wire logic short_interval,
   output logic      tick_r
);

   logic [12:0] frame_cnt_r;  // Frames seen in this interval
   logic [12:0] frame_cnt_nxt;
   logic [12:0] period;       // Interval length in frames
   logic        tick_nxt;

   // Interval length; a change of setting takes hold at the next wrap or sooner
   always_comb begin
      if (!short_interval) begin
         period = `FRAMES_ONE_SEC;
      end else if (e1_mode) begin
         period = `FRAMES_E1_SHORT;
      end else begin
         period = `FRAMES_T1_SHORT;
      end
      frame_cnt_nxt = frame_cnt_r;
      tick_nxt      = 1'b0;
      if (frame_strobe) begin
         // >= so that shortening the interval never strands the count
         if (frame_cnt_r >= 13'(period - `FRAME_ONE)) begin
            frame_cnt_nxt = 13'h0000;
            tick_nxt      = 1'b1;
         end else begin
            frame_cnt_nxt = 13'(frame_cnt_r + `FRAME_ONE);
         end
      end
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_cnt_r <= 13'h0000;
         tick_r      <= 1'b0;
      end else begin
         frame_cnt_r <= frame_cnt_nxt;
         tick_r      <= tick_nxt;
      end
   end

   a_tick_on_frame: assert property (@(posedge pclk) disable iff (!presetn)
      tick_r |-> $past(frame_strobe) && frame_cnt_r == 13'h0000)
      else $error("update tick without a frame boundary");

endmodule : update_timer

`default_nettype wire

//--- tb/framer_model.sv
`timescale 1ns/1ps
`default_nettype none

// Receive framer stand-in: modes, sync levels and one-cycle strobes
module framer_model (
   input  wire logic pclk,
   output logic [2:0] mode,  // Bit 0 E1, bit 1 ESF, bit 2 CRC4 multiframe
   output logic [4:0] lvl,   // Sync lost, FAS lost, CRC4 lost, FAS search, MF search
   output logic [8:0] ev     // CRC6,Ft,Fs,FPS,CRC4,FAS word,E-bit zero,frame,multiframe
);
   initial begin
      mode = 3'h0;
      lvl  = 5'h00;
      ev   = 9'h000;
   end

   // Levels move just after an edge, never together with a pulse edge
   task automatic set(input logic [2:0] m, input logic [4:0] l);
      @(posedge pclk);
      mode <= m;
      lvl  <= l;
   endtask : set

   // Each strobe is one cycle per event; gap=0 gives one event every cycle
   task automatic pulse(input logic [8:0] m, input int n, input logic gap);
      repeat (n) begin
         @(posedge pclk);
         ev <= m;
         if (gap) begin
            @(posedge pclk);
            ev <= 9'h000;
         end
      end
      @(posedge pclk);
      ev <= 9'h000;
   endtask : pulse
endmodule : framer_model

`default_nettype wire

//--- tb/path_frame_ebit_error_counters_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "err_cnt_regs.svh"

module path_frame_ebit_error_counters_tb;
   localparam logic [11:0] A_CFG = {`IDX_CFG, 2'b00};
   localparam logic [11:0] A_PV  = {`IDX_PV_HIGH, 2'b00};
   localparam logic [11:0] A_FS  = {`IDX_FS_HIGH, 2'b00};
   localparam logic [11:0] A_EB  = {`IDX_EB_HIGH, 2'b00};
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr;
   logic [2:0]  mode;
   logic [4:0]  lvl;
   logic [8:0]  ev;
   int          err_total, n_compared;

   framer_model fr (.pclk(pclk), .mode(mode), .lvl(lvl), .ev(ev));

   err_counters DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_e1_mode(mode[0]), .rx_esf_mode(mode[1]), .rx_crc4_mode(mode[2]),
      .frame_strobe(ev[7]), .multiframe_strobe(ev[8]), .receive_sync_lost(lvl[0]),
      .fas_sync_lost(lvl[1]), .crc4_sync_lost(lvl[2]), .fas_search(lvl[3]),
      .mf_search(lvl[4]), .crc6_err(ev[0]), .ft_err(ev[1]), .fs_err(ev[2]),
      .fps_err(ev[3]), .crc4_err(ev[4]), .fas_word_err(ev[5]), .ebit_zero(ev[6]));

   // Free-running 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Verdict and end of run, also reached on a hung wait
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   // Value compare, four-state exact
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One APB transfer: idle edge, setup, access held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         err_total++;
         $display("[ERR] pready expected 1 seen timeout");
         conclude();
      end
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   // Read and compare data and error flag
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic xe,
                     input string what);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(what, exp, r);
      chk({what, " slverr"}, {31'h0, xe}, {31'h0, e});
   endtask : rd

   // High byte then low byte of a 16-bit snapshot
   task automatic cnt(input logic [11:0] a, input logic [15:0] exp, input string what);
      rd(a, {24'h0, exp[15:8]}, 1'b0, {what, " high"});
      rd(a + 12'h004, {24'h0, exp[7:0]}, 1'b0, {what, " low"});
   endtask : cnt

   // Manual latch: rising edge of the latch bit snapshots and clears
   task automatic latch(input logic [7:0] c);
      wr(A_CFG, {24'h0, c | 8'h10});
      wr(A_CFG, {24'h0, c | 8'h50});
      wr(A_CFG, {24'h0, c | 8'h10});
   endtask : latch

   // Reset values, unmapped access, ignored count writes
   task automatic s_reset();
      cnt(A_PV, 16'h0000, "pv");
      cnt(A_FS, 16'h0000, "fs");
      cnt(A_EB, 16'h0000, "eb");
      rd(12'h000, 32'h0, 1'b1, "unmapped");
      wr(A_PV + 12'h004, 32'h0000_00A5);
      rd(A_PV + 12'h004, 32'h0, 1'b0, "pv low after write");
   endtask : s_reset

   // ESF: CRC6 and FPS counted, Fs option ignored, all held on sync loss
   task automatic s_esf();
      fr.set(3'b010, 5'h00);
      latch(8'h04);
      fr.pulse(9'h001, 3, 1'b1);
      fr.pulse(9'h004, 2, 1'b1);
      fr.pulse(9'h008, 1, 1'b1);
      fr.pulse(9'h040, 2, 1'b1);
      fr.set(3'b010, 5'h01);
      fr.pulse(9'h009, 2, 1'b1);
      latch(8'h04);
      cnt(A_PV, 16'h0003, "esf pv");
      cnt(A_FS, 16'h0001, "esf fs");
      cnt(A_EB, 16'h0000, "t1 eb");
   endtask : s_esf

   // D4: Ft always, Fs only with option; out-of-sync multiframes
   task automatic s_d4();
      fr.set(3'b000, 5'h00);
      fr.pulse(9'h002, 2, 1'b1);
      fr.pulse(9'h004, 1, 1'b1);
      latch(8'h00);
      cnt(A_PV, 16'h0003, "d4 fs on");
      // Multiframe mode from here on, so Ft errors no longer reach the frame sync count
      wr(A_CFG, 32'h0000_0012);
      fr.pulse(9'h002, 1, 1'b1);
      fr.pulse(9'h004, 2, 1'b1);
      fr.pulse(9'h100, 3, 1'b1);
      fr.set(3'b000, 5'h01);
      fr.pulse(9'h102, 4, 1'b1);
      latch(8'h02);
      cnt(A_PV, 16'h0001, "d4 fs off");
      cnt(A_FS, 16'h0004, "oos mf");
   endtask : s_d4

   // E1: CRC4, FAS word and E-bit counts with the various losses
   task automatic s_e1();
      fr.set(3'b101, 5'h00);
      latch(8'h00);
      fr.pulse(9'h070, 2, 1'b1);
      fr.set(3'b101, 5'h02);
      fr.pulse(9'h070, 1, 1'b1);
      fr.set(3'b101, 5'h04);
      fr.pulse(9'h070, 1, 1'b1);
      fr.set(3'b101, 5'h10);
      fr.pulse(9'h070, 1, 1'b1);
      fr.set(3'b101, 5'h08);
      fr.pulse(9'h020, 1, 1'b1);
      fr.set(3'b101, 5'h01);
      fr.pulse(9'h020, 1, 1'b1);
      // CRC4 multiframing off: FAS errors still count, E-bits do not
      fr.set(3'b001, 5'h00);
      fr.pulse(9'h060, 1, 1'b1);
      latch(8'h00);
      cnt(A_PV, 16'h0003, "e1 pv");
      cnt(A_FS, 16'h0005, "e1 fas");
      cnt(A_EB, 16'h0003, "e1 eb");
   endtask : s_e1

   // Automatic short interval: snapshot at frame 500 in E1, then at frame 333 in T1
   task automatic s_auto();
      wr(A_CFG, 32'h0000_0020);
      fr.pulse(9'h010, 5, 1'b1);
      fr.pulse(9'h080, 499, 1'b1);
      cnt(A_PV, 16'h0003, "before tick");
      fr.pulse(9'h080, 1, 1'b1);
      cnt(A_PV, 16'h0005, "after tick");
      fr.set(3'b000, 5'h00);
      fr.pulse(9'h002, 2, 1'b1);
      fr.pulse(9'h080, 332, 1'b1);
      cnt(A_PV, 16'h0005, "t1 before tick");
      fr.pulse(9'h080, 1, 1'b1);
      cnt(A_PV, 16'h0002, "t1 after tick");
   endtask : s_auto

   // Saturation with an event every cycle
   task automatic s_sat();
      latch(8'h00);
      fr.pulse(9'h002, 65540, 1'b0);
      latch(8'h00);
      cnt(A_PV, 16'hFFFF, "saturated");
   endtask : s_sat

   initial begin
      err_total  = 0;
      n_compared = 0;
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      s_reset();
      s_esf();
      s_d4();
      s_e1();
      s_auto();
      s_sat();
      conclude();
   end
endmodule : path_frame_ebit_error_counters_tb

`default_nettype wire
